// ---- hw/can_lp_pkg.sv ----
// constants, register map and state type of the can low-power controller
package can_lp_pkg;

	localparam int unsigned REG_W = 16;
	localparam int unsigned BUF_N = 32;
	localparam int unsigned IRQ_N = 35;

	// register word addresses
	localparam logic [3:0] ADDR_CFG      = 4'h0;
	localparam logic [3:0] ADDR_ESR      = 4'h1;
	localparam logic [3:0] ADDR_IMASK_HI = 4'h2;
	localparam logic [3:0] ADDR_IMASK_LO = 4'h3;

	// module_config_register fields
	localparam int unsigned CFG_STOP      = 15;
	localparam int unsigned CFG_SOFT_RST  = 14;
	localparam int unsigned CFG_SELF_WAKE = 13;
	localparam int unsigned CFG_APS       = 12;
	localparam int unsigned CFG_NOT_RDY   = 11;
	localparam int unsigned CFG_WAKE_MASK = 10;
	localparam int unsigned CFG_STOP_ACK  = 9;
	localparam int unsigned CFG_HALT      = 8;
	localparam int unsigned CFG_ERR_MASK  = 7;
	localparam int unsigned CFG_BOFF_MASK = 6;

	// error and status register fields
	localparam int unsigned ESR_STOPPED  = 0;
	localparam int unsigned ESR_BUS_OFF  = 1;
	localparam int unsigned ESR_WAKE_INT = 2;

	// interrupt vector positions above the message buffers
	localparam int unsigned IRQ_BOFF = 32;
	localparam int unsigned IRQ_ERR  = 33;
	localparam int unsigned IRQ_WAKE = 34;

	localparam logic        HALT_RST  = 1'b1;
	localparam logic        RECESSIVE = 1'b1;
	localparam logic [3:0]  SYNC_BITS = 4'd11;
	localparam logic [15:0] ZERO16    = 16'h0000;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_RESYNC,
		ST_WAIT_BUS,
		ST_WAIT_INT,
		ST_STOPPED
	} lp_state_e;

endpackage

// ---- hw/lp_link_if.sv ----
// signals between the low-power core and its edge and gating helpers
`timescale 1ns/1ps
`default_nettype none
interface lp_link_if;
	logic rx_level;
	logic fall;
	logic aps_en;
	logic gate_ok;
	logic gate_off;
	logic gate_woke;

	modport edge_mp (input rx_level, output fall);
	modport gate_mp (input aps_en, input gate_ok, output gate_off,
		output gate_woke);
	modport core_mp (output rx_level, input fall, output aps_en,
		output gate_ok, input gate_off, input gate_woke);
endinterface
`default_nettype wire

// ---- hw/can_bus_edge.sv ----
// recessive-to-dominant edge detector on the raw bus receive level
`timescale 1ns/1ps
`default_nettype none
module can_bus_edge (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	lp_link_if.edge_mp lnk
);
	logic prev_q;

	// runs on the free bus-interface clock, so it works while stopped
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= can_lp_pkg::RECESSIVE;
		end else begin
			prev_q <= lnk.rx_level;
		end
	end

	assign lnk.fall = (prev_q == can_lp_pkg::RECESSIVE) &&
		(lnk.rx_level != can_lp_pkg::RECESSIVE);
endmodule
`default_nettype wire

// ---- hw/can_auto_gate.sv ----
// automatic idle clock gating decision
`timescale 1ns/1ps
`default_nettype none
module can_auto_gate (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	lp_link_if.gate_mp lnk
);
	logic off_q;

	// combinational so the clock restarts in the cycle a condition fails
	assign lnk.gate_off = lnk.aps_en && lnk.gate_ok;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			off_q <= 1'b0;
		end else begin
			off_q <= lnk.gate_off;
		end
	end

	assign lnk.gate_woke = off_q && !lnk.gate_off;
endmodule
`default_nettype wire

// ---- hw/can_low_power_control.sv ----
// low-power control of a can controller: stop mode, self-wake, auto gating
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module can_low_power_control (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic        can_rx_i,
	output logic             can_tx_o,
	input  wire logic        core_tx_i,
	output logic             core_rx_o,
	input  wire logic        bit_tick_i,
	input  wire logic        bus_idle_i,
	input  wire logic        int3_recessive_i,
	input  wire logic        internal_busy_i,
	input  wire logic        frame_active_i,
	input  wire logic        buf_move_i,
	input  wire logic        tx_pending_i,
	input  wire logic        bus_off_i,
	input  wire logic [31:0] buf_irq_i,
	input  wire logic        err_irq_i,
	input  wire logic        boff_irq_i,
	output logic             clk_en_o,
	output logic             halt_o,
	output logic             sync_lost_o,
	output logic             wake_sof_o,
	output logic             arb_inhibit_o,
	output logic             resync_edge_o,
	output logic             boff_freeze_o,
	output logic             soft_rst_o,
	output logic      [34:0] irq_o
);
	logic rst_meta_q;
	logic rst_n_q;

	// reset release through two flops
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	function automatic logic hit(input logic [3:0] a,
		input logic [3:0] ref_a);
		hit = (a == ref_a);
	endfunction

	lp_link_if lnk ();

	can_bus_edge u_edge (
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n_q),
		.lnk     (lnk.edge_mp)
	);

	can_auto_gate u_gate (
		.clk_i   (clk_sys_i),
		.rst_n_i (rst_n_q),
		.lnk     (lnk.gate_mp)
	);

	can_lp_pkg::lp_state_e state_q, state_d;
	logic        stop_q, stop_d;
	logic        halt_q, halt_d;
	logic        self_wake_q;
	logic        aps_q;
	logic        wake_mask_q;
	logic        err_mask_q;
	logic        boff_mask_q;
	logic [31:0] imask_q;
	logic        wake_int_q;
	logic        sw_latched_q, sw_latched_d;
	logic [3:0]  sync_cnt_q, sync_cnt_d;
	logic        soft_rst_q;
	logic        fix_pend_q;
	logic        resync_q;
	logic        wake_sof_q;
	logic        arb_inh_q;
	logic [15:0] rdata_q;
	logic [34:0] irq_q;

	wire stopped     = (state_q == can_lp_pkg::ST_STOPPED);
	wire host_access = reg_wr_i || reg_rd_i;
	wire wr_cfg      = reg_wr_i && hit(reg_addr_i, can_lp_pkg::ADDR_CFG);
	wire wr_esr      = reg_wr_i && hit(reg_addr_i, can_lp_pkg::ADDR_ESR);
	wire wr_imh      = reg_wr_i &&
		hit(reg_addr_i, can_lp_pkg::ADDR_IMASK_HI);
	wire wr_iml      = reg_wr_i &&
		hit(reg_addr_i, can_lp_pkg::ADDR_IMASK_LO);
	wire bus_fall    = lnk.fall;
	wire not_rdy     = stopped || halt_q;
	wire stop_wait   = (state_q == can_lp_pkg::ST_RESYNC) ||
		(state_q == can_lp_pkg::ST_WAIT_BUS) ||
		(state_q == can_lp_pkg::ST_WAIT_INT);
	// with self-wake on, an edge before the ack leaves no stop entry at all
	wire early_wake  = stop_wait && stop_q && self_wake_q && bus_fall;
	wire edge_wake   = stopped && sw_latched_q && bus_fall;
	wire stop_hw_clr = early_wake || edge_wake;
	wire wake_set    = stopped && bus_fall;
	wire recess_bit  = bit_tick_i && (can_rx_i == can_lp_pkg::RECESSIVE);

	assign lnk.rx_level = can_rx_i;
	assign lnk.aps_en   = aps_q;
	assign lnk.gate_ok  = !frame_active_i && !buf_move_i &&
		!tx_pending_i && !host_access &&
		!halt_q && !stop_q && !bus_off_i;

	// stop request sequence
	always_comb begin
		state_d      = state_q;
		sync_cnt_d   = sync_cnt_q;
		sw_latched_d = sw_latched_q;
		halt_d       = halt_q;
		case (state_q)
			can_lp_pkg::ST_RUN: begin
				sync_cnt_d = 4'h0;
				if (stop_q && halt_q) begin
					halt_d  = 1'b0;
					state_d = can_lp_pkg::ST_RESYNC;
				end else if (stop_q) begin
					state_d = can_lp_pkg::ST_WAIT_BUS;
				end
			end
			can_lp_pkg::ST_RESYNC: begin
				if (recess_bit) begin
					sync_cnt_d = sync_cnt_q + 4'h1;
				end else if (bit_tick_i) begin
					sync_cnt_d = 4'h0;
				end
				if (!stop_q || early_wake) begin
					state_d = can_lp_pkg::ST_RUN;
				end else if (sync_cnt_q == can_lp_pkg::SYNC_BITS) begin
					state_d = can_lp_pkg::ST_WAIT_BUS;
				end
			end
			can_lp_pkg::ST_WAIT_BUS: begin
				if (!stop_q || early_wake) begin
					state_d = can_lp_pkg::ST_RUN;
				end else if (bus_idle_i || int3_recessive_i) begin
					state_d = can_lp_pkg::ST_WAIT_INT;
				end
			end
			can_lp_pkg::ST_WAIT_INT: begin
				if (!stop_q || early_wake) begin
					state_d = can_lp_pkg::ST_RUN;
				end else if (!internal_busy_i) begin
					state_d      = can_lp_pkg::ST_STOPPED;
					sw_latched_d = self_wake_q;
				end
			end
			can_lp_pkg::ST_STOPPED: begin
				if (!stop_q || edge_wake) begin
					state_d      = can_lp_pkg::ST_RUN;
					sw_latched_d = 1'b0;
				end
			end
			default: begin
				state_d = can_lp_pkg::ST_RUN;
			end
		endcase
		if (wr_cfg) begin
			halt_d = reg_wdata_i[can_lp_pkg::CFG_HALT];
		end
		if (state_q == can_lp_pkg::ST_RUN && stop_q && halt_q) begin
			halt_d = 1'b0;
		end
	end

	// hardware clear of stop wins over a host write in the same cycle
	always_comb begin
		stop_d = stop_q;
		if (wr_cfg) begin
			stop_d = reg_wdata_i[can_lp_pkg::CFG_STOP];
		end
		if (stop_hw_clr) begin
			stop_d = 1'b0;
		end
	end

	// soft reset acts one cycle after the write and clears the state, control, mask and wake flag registers as a hard reset does
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= wr_cfg && reg_wdata_i[can_lp_pkg::CFG_SOFT_RST];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q      <= can_lp_pkg::ST_RUN;
			stop_q       <= 1'b0;
			halt_q       <= can_lp_pkg::HALT_RST;
			sw_latched_q <= 1'b0;
			sync_cnt_q   <= 4'h0;
		end else if (soft_rst_q) begin
			state_q      <= can_lp_pkg::ST_RUN;
			stop_q       <= 1'b0;
			halt_q       <= can_lp_pkg::HALT_RST;
			sw_latched_q <= 1'b0;
			sync_cnt_q   <= 4'h0;
		end else begin
			state_q      <= state_d;
			stop_q       <= stop_d;
			halt_q       <= halt_d;
			sw_latched_q <= sw_latched_d;
			sync_cnt_q   <= sync_cnt_d;
		end
	end

	// control bits and masks written by software
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			self_wake_q <= 1'b0;
			aps_q       <= 1'b0;
			wake_mask_q <= 1'b0;
			err_mask_q  <= 1'b0;
			boff_mask_q <= 1'b0;
			imask_q     <= 32'h0000_0000;
		end else if (soft_rst_q) begin
			self_wake_q <= 1'b0;
			aps_q       <= 1'b0;
			wake_mask_q <= 1'b0;
			err_mask_q  <= 1'b0;
			boff_mask_q <= 1'b0;
			imask_q     <= 32'h0000_0000;
		end else begin
			if (wr_cfg) begin
				self_wake_q <= reg_wdata_i[can_lp_pkg::CFG_SELF_WAKE];
				aps_q       <= reg_wdata_i[can_lp_pkg::CFG_APS];
				wake_mask_q <= reg_wdata_i[can_lp_pkg::CFG_WAKE_MASK];
				err_mask_q  <= reg_wdata_i[can_lp_pkg::CFG_ERR_MASK];
				boff_mask_q <= reg_wdata_i[can_lp_pkg::CFG_BOFF_MASK];
			end
			if (wr_imh) begin
				imask_q[31:16] <= reg_wdata_i;
			end
			if (wr_iml) begin
				imask_q[15:0] <= reg_wdata_i;
			end
		end
	end

	// wake flag: write one to clear, a new edge wins over the clear
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wake_int_q <= 1'b0;
		end else if (soft_rst_q) begin
			wake_int_q <= 1'b0;
		end else begin
			wake_int_q <= wake_set || (wake_int_q &&
				!(wr_esr && reg_wdata_i[can_lp_pkg::ESR_WAKE_INT]));
		end
	end

	// wake bookkeeping for the protocol engine
	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wake_sof_q <= 1'b0;
			arb_inh_q  <= 1'b0;
			fix_pend_q <= 1'b0;
			resync_q   <= 1'b0;
		end else begin
			wake_sof_q <= edge_wake;
			if (edge_wake) begin
				arb_inh_q <= 1'b1;
			end else if (bus_idle_i) begin
				arb_inh_q <= 1'b0;
			end
			resync_q <= fix_pend_q && bus_fall;
			if (edge_wake || lnk.gate_woke) begin
				fix_pend_q <= 1'b1;
			end else if (bus_fall) begin
				fix_pend_q <= 1'b0;
			end
		end
	end

	// read port stays on the free clock even while stopped
	wire [15:0] cfg_rd = {stop_q, 1'b0, self_wake_q, aps_q, not_rdy,
		wake_mask_q, stopped, halt_q, err_mask_q, boff_mask_q, 6'h00};
	wire [15:0] esr_rd = {13'h0000, wake_int_q, bus_off_i, stopped};
	wire [15:0] rd_mux =
		hit(reg_addr_i, can_lp_pkg::ADDR_CFG)      ? cfg_rd :
		hit(reg_addr_i, can_lp_pkg::ADDR_ESR)      ? esr_rd :
		hit(reg_addr_i, can_lp_pkg::ADDR_IMASK_HI) ? imask_q[31:16] :
		hit(reg_addr_i, can_lp_pkg::ADDR_IMASK_LO) ? imask_q[15:0] :
		can_lp_pkg::ZERO16;

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= reg_rd_i ? rd_mux : can_lp_pkg::ZERO16;
		end
	end

	// per-source gating of the interrupt vector
	wire [34:0] irq_d = {
		wake_int_q && wake_mask_q,
		err_irq_i && err_mask_q,
		boff_irq_i && boff_mask_q,
		buf_irq_i & imask_q
	};

	always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_q <= 35'h0_0000_0000;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign reg_rdata_o   = rdata_q;
	assign irq_o         = irq_q;
	// outside stop the tx pin follows the core with no added latency
	assign can_tx_o      = stopped ? can_lp_pkg::RECESSIVE : core_tx_i;
	assign core_rx_o     = stopped ? can_lp_pkg::RECESSIVE : can_rx_i;
	assign clk_en_o      = !stopped && !lnk.gate_off;
	assign sync_lost_o   = stopped;
	assign halt_o        = halt_q;
	assign wake_sof_o    = wake_sof_q;
	assign arb_inhibit_o = arb_inh_q;
	assign resync_edge_o = resync_q;
	assign boff_freeze_o = stopped && bus_off_i;
	assign soft_rst_o    = soft_rst_q;
endmodule
`default_nettype wire

// ---- tb/can_bus_node.sv ----
// behavioural bus node: idle recessive, sends one short burst on request
`timescale 1ns/1ps
`default_nettype none
module can_bus_node #(
	parameter int TQ = 4
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [7:0] bits_i,
	output logic            rx_o,
	output logic            idle_o,
	output logic            tick_o
);
	logic [7:0] sh_q;
	logic [3:0] n_q;
	int         c_q;
	// bit clock keeps bit time between frames too, but restarts at zero when a burst starts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c_q <= 0;
			n_q <= 4'h0;
			sh_q <= 8'hff;
		end else if (start_i && n_q == 4'h0) begin
			c_q <= 0;
			n_q <= 4'h8;
			sh_q <= bits_i;
		end else begin
			c_q <= (c_q == TQ - 1) ? 0 : c_q + 1;
			if (c_q == TQ - 1 && n_q != 4'h0) begin
				n_q <= n_q - 4'h1;
				sh_q <= {sh_q[6:0], 1'b1};
			end
		end
	end
	// a released bus is pulled recessive
	assign rx_o = (n_q != 4'h0) ? sh_q[7] : 1'b1;
	assign idle_o = n_q == 4'h0;
	assign tick_o = c_q == TQ - 1;
endmodule
`default_nettype wire

// ---- tb/can_lp_monitor.sv ----
// port checks of the can low-power control block
`timescale 1ns/1ps
`default_nettype none
module can_lp_monitor (
	input wire logic        clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i, reg_rdata_o,
	input wire logic        can_rx_i, can_tx_o, core_rx_o, bus_idle_i,
	input wire logic        frame_active_i, buf_move_i, tx_pending_i,
	input wire logic        bus_off_i, clk_en_o, halt_o, sync_lost_o,
	input wire logic        wake_sof_o, arb_inhibit_o, resync_edge_o,
	input wire logic        boff_freeze_o, soft_rst_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	wire logic cfg_wr = reg_wr_i && reg_addr_i == can_lp_pkg::ADDR_CFG;
	wire logic cfg_rd = reg_rd_i && reg_addr_i == can_lp_pkg::ADDR_CFG;
	AST_TX_RECESSIVE: assert property (sync_lost_o |-> can_tx_o)
		else $error("transmit not recessive while stopped");
	AST_RX_IGNORED: assert property (sync_lost_o |-> core_rx_o)
		else $error("receive passed through while stopped");
	AST_CLK_GATED: assert property (sync_lost_o |-> !clk_en_o)
		else $error("clock running while stopped");
	AST_FREEZE: assert property (boff_freeze_o ==
		(sync_lost_o && bus_off_i))
		else $error("recovery freeze wrong");
	AST_WAKE_SOF: assert property (wake_sof_o |-> !$past(can_rx_i)
		&& $past(can_rx_i, 2) && !sync_lost_o && arb_inhibit_o)
		else $error("frame start without bus edge");
	AST_ARB_CLEAR: assert property (arb_inhibit_o && bus_idle_i
		&& !sync_lost_o |=> !arb_inhibit_o)
		else $error("arbitration hold outlived idle bus");
	AST_SOFT_RESET: assert property (cfg_wr && reg_wdata_i[14]
		|=> soft_rst_o ##1 !sync_lost_o)
		else $error("soft reset did not end stop");
	AST_ACK_READ: assert property (cfg_rd |=> reg_rdata_o[9] ==
		$past(sync_lost_o) && reg_rdata_o[11] == $past(sync_lost_o || halt_o))
		else $error("ack or unready flag wrong");
	AST_RESYNC: assert property (resync_edge_o |-> !$past(can_rx_i)
		&& $past(can_rx_i, 2))
		else $error("resync without falling edge");
	AST_GATE_BUSY: assert property (!sync_lost_o && (reg_wr_i
		|| reg_rd_i || frame_active_i || buf_move_i || tx_pending_i)
		|-> clk_en_o)
		else $error("clock gated while busy");
	AST_GATE_BLOCK: assert property (!sync_lost_o && (halt_o || bus_off_i)
		|-> clk_en_o)
		else $error("clock gated in halt or bus-off");
endmodule
bind can_low_power_control can_lp_monitor mon (.clk_sys_i, .reset_n_i,
	.reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .can_rx_i,
	.can_tx_o, .core_rx_o, .bus_idle_i, .frame_active_i, .buf_move_i,
	.tx_pending_i, .bus_off_i, .clk_en_o, .halt_o, .sync_lost_o, .wake_sof_o,
	.arb_inhibit_o, .resync_edge_o, .boff_freeze_o, .soft_rst_o);
`default_nettype wire

// ---- tb/can_low_power_control_test.sv ----
// self-checking bench of the can low-power control block
`timescale 1ns/1ps
`default_nettype none
module can_low_power_control_test;
	localparam int TQ = 4;
	localparam logic [3:0] CFG = can_lp_pkg::ADDR_CFG;
	localparam logic [3:0] ESR = can_lp_pkg::ADDR_ESR;
	logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0, core_tx_i = 1'b0, int3_recessive_i = 1'b0;
	logic        internal_busy_i = 1'b0, frame_active_i = 1'b0;
	logic        buf_move_i = 1'b0, tx_pending_i = 1'b0, bus_off_i = 1'b0;
	logic        err_irq_i = 1'b0, boff_irq_i = 1'b0, start = 1'b0, any;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
	logic [31:0] buf_irq_i = 32'h0, msk;
	logic [34:0] irq_o;
	logic [7:0]  bits = 8'h55;
	logic        can_rx_i, can_tx_o, core_rx_o, bit_tick_i, bus_idle_i;
	logic        clk_en_o, halt_o, sync_lost_o, wake_sof_o, arb_inhibit_o;
	logic        resync_edge_o, boff_freeze_o, soft_rst_o;
	int          err_total = 0, cmp_count = 0, n;

	can_low_power_control DUT (.clk_sys_i, .reset_n_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .can_rx_i, .can_tx_o,
		.core_tx_i, .core_rx_o, .bit_tick_i, .bus_idle_i, .int3_recessive_i,
		.internal_busy_i, .frame_active_i, .buf_move_i, .tx_pending_i,
		.bus_off_i, .buf_irq_i, .err_irq_i, .boff_irq_i, .clk_en_o, .halt_o,
		.sync_lost_o, .wake_sof_o, .arb_inhibit_o, .resync_edge_o,
		.boff_freeze_o, .soft_rst_o, .irq_o);
	can_bus_node #(.TQ(TQ)) node (.clk_i(clk_sys_i), .rst_n_i(reset_n_i),
		.start_i(start), .bits_i(bits), .rx_o(can_rx_i), .idle_o(bus_idle_i),
		.tick_o(bit_tick_i));

	always #50 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk(reg_rdata_o, e);
	endtask
	// n ends as the number of cycles waited
	task automatic wait_stop(input logic s);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (sync_lost_o !== s && n < 400);
		chk(sync_lost_o, s);
	endtask
	task automatic idle_wait;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (bus_idle_i !== 1'b1 && n < 99);
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys_i);
		bits <= b;
		start <= 1'b1;
		@(posedge clk_sys_i);
		start <= 1'b0;
	endtask
	function automatic logic [15:0] cfg_exp(input logic [15:0] w,
		input logic s);
		cfg_exp = (w & 16'hb5c0) | {4'h0, s | w[8], 1'b0, s, 9'h000};
	endfunction
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_total++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h57da7b2d));
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rd(CFG, 16'h0900);
		msk = $urandom;
		wr(can_lp_pkg::ADDR_IMASK_HI, msk[31:16]);
		wr(can_lp_pkg::ADDR_IMASK_LO, msk[15:0]);
		wr(CFG, 16'h0140);
		rd(can_lp_pkg::ADDR_IMASK_HI, msk[31:16]);
		rd(4'h9, 16'h0000);
		repeat (6) begin
			@(posedge clk_sys_i);
			buf_irq_i <= $urandom;
			{err_irq_i, boff_irq_i} <= 2'($urandom);
			repeat (3) @(negedge clk_sys_i);
			chk(irq_o, {2'b00, boff_irq_i, buf_irq_i & msk});
		end
		$display("test vector done");
		@(posedge clk_sys_i);
		buf_irq_i <= 32'h0;
		wr(CFG, 16'h8100);
		wait_stop(1'b1);
		chk(n >= 10 * TQ, 1'b1);
		rd(CFG, cfg_exp(16'h8000, 1'b1));
		rd(ESR, 16'h0001);
		chk({clk_en_o, can_tx_o, core_rx_o}, 3'b011);
		wr(CFG, 16'h0000);
		wait_stop(1'b0);
		rd(CFG, 16'h0000);
		$display("test stop done");
		// self-wake: a bus edge in stop ends it and flags the frame start; an edge before the ack cancels the stop
		wr(CFG, 16'ha400);
		wait_stop(1'b1);
		send(8'h55);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (wake_sof_o !== 1'b1 && n < 60);
		chk({wake_sof_o, arb_inhibit_o, sync_lost_o}, 3'b110);
		rd(CFG, 16'h2400);
		chk(irq_o[34], 1'b1);
		idle_wait();
		rd(ESR, 16'h0004);
		wr(ESR, 16'h0004);
		rd(ESR, 16'h0000);
		chk(irq_o[34], 1'b0);
		send(8'h55);
		wr(CFG, 16'ha400);
		idle_wait();
		rd(CFG, 16'h2400);
		$display("test self-wake done");
		wr(CFG, 16'h0000);
		@(posedge clk_sys_i);
		bus_off_i <= 1'b1;
		internal_busy_i <= 1'b1;
		wr(CFG, 16'h8000);
		// long enough to pass the bus wait, short of the busy release
		repeat (20) @(negedge clk_sys_i);
		chk(sync_lost_o, 1'b0);
		@(posedge clk_sys_i);
		internal_busy_i <= 1'b0;
		wait_stop(1'b1);
		chk(boff_freeze_o, 1'b1);
		send(8'h55);
		@(negedge clk_sys_i);
		chk({core_rx_o, can_rx_i}, 2'b10);
		idle_wait();
		chk(sync_lost_o, 1'b1);
		rd(ESR, 16'h0007);
		chk(irq_o[34], 1'b0);
		wr(CFG, 16'h4000);
		rd(CFG, 16'h0900);
		chk({sync_lost_o, boff_freeze_o}, 2'b00);
		$display("test bus-off done");
		wr(CFG, 16'h1000);
		repeat (60) begin
			@(posedge clk_sys_i);
			{frame_active_i, buf_move_i, tx_pending_i, bus_off_i,
				core_tx_i} <= 5'($urandom & $urandom);
			@(negedge clk_sys_i);
			any = frame_active_i | buf_move_i | tx_pending_i | bus_off_i;
			chk({clk_en_o, can_tx_o}, {any, core_tx_i});
		end
		@(posedge clk_sys_i);
		{frame_active_i, buf_move_i, tx_pending_i, bus_off_i} <= 4'h0;
		wr(CFG, 16'h1100);
		@(negedge clk_sys_i);
		chk({clk_en_o, halt_o}, 2'b11);
		$display("test gating done");
		wrap_up();
	end
endmodule
`default_nettype wire
